// ---- verilog/pig_top.sv ----
// module: interrupt generation for endpoint, root port and bridge modes
`timescale 1ns/1ps
module pig_top #(
  parameter int NIRQ = pig_pkg::NUM_IRQ_IN
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  root_mode,
  input  wire logic                  msix_impl,
  input  wire pig_pkg::pig_cfgwr_s   cfg_wr,
  input  wire logic                  msi_req_in,
  input  wire logic [2:0]            msi_traffic_class_in,
  input  wire logic [4:0]            msi_num_in,
  input  wire logic                  legacy_irq_vector_in,
  input  wire logic                  pme_event_in,
  input  wire logic                  syserr_event_in,
  input  wire logic [4:0]            aer_msi_num_in,
  input  wire logic [4:0]            pme_msi_ofs_in,
  input  wire logic                  aer_err_log_in,
  input  wire logic                  rx_msg_valid,
  input  wire logic [7:0]            rx_msg_code,
  input  wire logic                  rx_mwr_valid,
  input  wire logic [63:0]           rx_mwr_data,
  input  wire logic [NIRQ-1:0]       bridge_irq_inputs,
  input  wire logic                  crs_wr,
  input  wire logic                  crs_rd,
  input  wire logic [13:0]           crs_addr,
  input  wire logic [31:0]           crs_wdata,
  input  wire logic                  tx_ready,
  output logic                       msi_ack_out,
  output logic                       tx_valid,
  output pig_pkg::pig_tlp_s          tx_tlp,
  output logic [1:0]                 irq_mode,
  output logic [15:0]                config_control_bus,
  output logic                       rx_app_valid,
  output logic [63:0]                rx_app_data,
  output logic [3:0]                 root_int_status,
  output logic [31:0]                aer_root_status,
  output logic [31:0]                crs_rdata,
  output logic                       crs_rvalid
);
  // configuration registers
  logic        intdis_r, msi_en_r, msix_en_r, msix_fmask_r;
  logic [2:0]  mme_r;
  logic [31:0] msi_addr_r;
  logic [15:0] msi_data_r;
  logic [31:0] aer_root_status_r;
  // bridge registers
  logic [31:0] stat_r, enable_r;
  wire  [31:0] stat_nxt;
  logic [NIRQ-1:0] irq_s1_r, irq_s2_r;
  // tlp engine state
  logic        busy_r, ack_r, tx_valid_r, legacy_lvl_r;
  pig_pkg::pig_tlp_s tlp_r;
  logic [3:0]  root_int_r;
  logic        rx_v_r;
  logic [63:0] rx_d_r;
  logic [31:0] rdata_r;
  logic        rvalid_r;
  logic        pend_pme_r, pend_err_r, pend_aer_r;

  pig_pkg::pig_mode_e mode;
  wire cfg_cmd  = cfg_wr.wr && cfg_wr.addr == pig_pkg::CFG_CMD_OFS;
  wire cfg_msi  = cfg_wr.wr && cfg_wr.addr == pig_pkg::CFG_MSI_OFS;
  wire cfg_addr = cfg_wr.wr && cfg_wr.addr == pig_pkg::CFG_MSI_ADDR_OFS;
  wire cfg_data = cfg_wr.wr && cfg_wr.addr == pig_pkg::CFG_MSI_DATA_OFS;
  wire cfg_aer  = cfg_wr.wr && cfg_wr.addr == pig_pkg::CFG_AER_RES_OFS;

  // mode resolves one type; msi outranks msix outranks wire
  always_comb begin
    if (msi_en_r) mode = pig_pkg::PIG_MODE_MSI;
    else if (msix_en_r && msix_impl) mode = pig_pkg::PIG_MODE_MSIX;
    else if (!intdis_r) mode = pig_pkg::PIG_MODE_LEGACY;
    else mode = pig_pkg::PIG_MODE_NONE;
  end
  wire msi_mode = (mode == pig_pkg::PIG_MODE_MSI);
  wire leg_mode = (mode == pig_pkg::PIG_MODE_LEGACY);

  // configuration writes; power-up leaves msi off so wire mode rules
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      intdis_r <= 1'b0; msi_en_r <= 1'b0; mme_r <= 3'h0;
      msix_en_r <= 1'b0; msix_fmask_r <= 1'b0;
      msi_addr_r <= 32'h0000_0000; msi_data_r <= 16'h0000;
    end else begin
      if (cfg_cmd) intdis_r <= cfg_wr.data[pig_pkg::CFG_CMD_INTDIS];
      if (cfg_msi) begin
        msi_en_r <= cfg_wr.data[pig_pkg::CFG_MSI_EN_BIT];
        mme_r    <= cfg_wr.data[pig_pkg::CFG_MSI_MME_LO +: 3];
        msix_en_r    <= cfg_wr.data[pig_pkg::CFG_MSIX_EN_BIT];
        msix_fmask_r <= cfg_wr.data[pig_pkg::CFG_MSIX_FM_BIT];
      end
      if (cfg_addr) msi_addr_r <= cfg_wr.data;
      if (cfg_data) msi_data_r <= cfg_wr.data[15:0];
    end
  end

  // bridge interrupt inputs come from outside: two flops first
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_s1_r <= '0; irq_s2_r <= '0;
    end else begin
      irq_s1_r <= bridge_irq_inputs;
      irq_s2_r <= irq_s1_r;
    end
  end

  // status: input bits follow level, mailbox bits sticky, set beats clear
  wire crs_wr_stat = crs_wr && crs_addr == pig_pkg::REG_STATUS_OFS;
  wire crs_wr_en   = crs_wr && crs_addr == pig_pkg::REG_ENABLE_OFS;
  wire crs_wr_mbox = crs_wr && crs_addr[13:4] == pig_pkg::REG_MAILBOX_OFS[13:4];
  wire [31:0] mbox_set = crs_wr_mbox ? (32'h1 << (pig_pkg::MBOX_BIT_LO + crs_addr[3:0])) : 32'h0;
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_stat
      if (gi < NIRQ) begin : g_in
        assign stat_nxt[gi] = irq_s2_r[gi];
      end else if (gi >= pig_pkg::MBOX_BIT_LO) begin : g_mb
        assign stat_nxt[gi] = mbox_set[gi] | (stat_r[gi] & ~(crs_wr_stat & crs_wdata[gi]));
      end else begin : g_rs
        assign stat_nxt[gi] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stat_r <= 32'h0000_0000; enable_r <= pig_pkg::ENABLE_RESET;
    end else begin
      stat_r <= stat_nxt;
      if (crs_wr_en) enable_r <= crs_wdata;
    end
  end

  // register reads, answered one cycle after the strobe
  wire [31:0] rd_mux = (crs_addr == pig_pkg::REG_STATUS_OFS) ? stat_r :
                       (crs_addr == pig_pkg::REG_ENABLE_OFS) ? enable_r : 32'h0000_0000;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_r <= 32'h0; rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= crs_rd;
      rdata_r  <= crs_rd ? rd_mux : 32'h0;
    end
  end

  // enabled pending bits drive the bridge request
  wire        bridge_pend = |(stat_r & enable_r);
  logic       bridge_sent_r;
  wire        bridge_msi  = bridge_pend && !bridge_sent_r && msi_mode && !root_mode;

  // engine selects, declared ahead of the pending flags that read them
  logic sel_err, sel_aer, sel_pme, sel_brg, sel_app, go;

  // internal events wait for the engine
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pend_pme_r <= 1'b0; pend_err_r <= 1'b0; pend_aer_r <= 1'b0;
    end else begin
      pend_pme_r <= pme_event_in | (pend_pme_r & ~(sel_pme & go));
      pend_err_r <= syserr_event_in | (pend_err_r & ~(sel_err & go));
      pend_aer_r <= (aer_err_log_in & root_mode) | (pend_aer_r & ~(sel_aer & go));
    end
  end

  // priority: system error, aer, power, bridge, application
  assign sel_err = pend_err_r;
  assign sel_aer = !sel_err && pend_aer_r;
  assign sel_pme = !sel_err && !sel_aer && pend_pme_r;
  assign sel_brg = !pend_err_r && !pend_aer_r && !pend_pme_r && bridge_msi;
  assign sel_app = !pend_err_r && !pend_aer_r && !pend_pme_r && !bridge_msi && msi_req_in && !ack_r;
  assign go = msi_mode && !busy_r && (sel_err | sel_aer | sel_pme | sel_brg | sel_app);

  logic [1:0] cls;
  logic [4:0] num;
  logic [15:0] vec_data;
  assign cls = sel_err ? 2'd2 : (sel_pme ? 2'd1 : 2'd0);
  assign num = sel_aer ? aer_msi_num_in : (sel_pme && root_mode ? pme_msi_ofs_in : msi_num_in);

  pig_msi_vec u_vec (
    .alloc_mme (mme_r),
    .app_num   (num),
    .src_class (root_mode && sel_pme ? 2'd0 : cls),
    .base_data (msi_data_r),
    .msg_data  (vec_data)
  );

  // wire-interrupt level: app vector or bridge pending
  wire leg_want = leg_mode && (legacy_irq_vector_in | bridge_pend) && !root_mode;
  wire leg_go   = !busy_r && !go && (leg_want != legacy_lvl_r);

  // single tlp engine; holds the tlp until the link takes it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      busy_r <= 1'b0; tx_valid_r <= 1'b0; ack_r <= 1'b0;
      legacy_lvl_r <= 1'b0; bridge_sent_r <= 1'b0;
      tlp_r <= '0;
    end else begin
      ack_r <= go && sel_app;
      if (!bridge_pend) bridge_sent_r <= 1'b0;
      if (go) begin
        busy_r <= 1'b1; tx_valid_r <= 1'b1;
        tlp_r.fmt_type <= pig_pkg::TLP_MWR32;
        tlp_r.tc <= sel_app ? msi_traffic_class_in : pig_pkg::traffic_class_zero;
        tlp_r.last_be <= pig_pkg::LAST_BE_NONE;
        tlp_r.first_be <= pig_pkg::FIRST_BE_ALL;
        tlp_r.msg_code <= 8'h00;
        tlp_r.addr <= msi_addr_r;
        tlp_r.data <= {16'h0000, vec_data};
        if (sel_brg) bridge_sent_r <= 1'b1;
      end else if (leg_go) begin
        busy_r <= 1'b1; tx_valid_r <= 1'b1; legacy_lvl_r <= leg_want;
        tlp_r.fmt_type <= pig_pkg::TLP_MSG_ASSERT;
        tlp_r.tc <= pig_pkg::traffic_class_zero;
        tlp_r.last_be <= pig_pkg::LAST_BE_NONE;
        tlp_r.first_be <= pig_pkg::LAST_BE_NONE;
        tlp_r.msg_code <= leg_want ? pig_pkg::MSG_ASSERT_A : pig_pkg::MSG_DEASSERT_A;
        tlp_r.addr <= 32'h0; tlp_r.data <= 32'h0;
      end else if (tx_valid_r && tx_ready) begin
        busy_r <= 1'b0; tx_valid_r <= 1'b0;
      end
    end
  end

  // root port: msi writes pass, wire messages map to status bits
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      root_int_r <= 4'h0; rx_v_r <= 1'b0; rx_d_r <= 64'h0;
      aer_root_status_r <= 32'h0;
    end else begin
      rx_v_r <= root_mode && rx_mwr_valid;
      rx_d_r <= rx_mwr_data;
      if (root_mode && rx_msg_valid && rx_msg_code[7:3] == pig_pkg::MSG_ASSERT_A[7:3]) begin
        root_int_r[rx_msg_code[1:0]] <= ~rx_msg_code[2];
      end
      if (root_mode && aer_err_log_in) aer_root_status_r[0] <= 1'b1;
      else if (cfg_aer && cfg_wr.data[0]) aer_root_status_r[0] <= 1'b0;
    end
  end

  // command, msi and msix control bits exposed for the app's own writes
  logic [15:0] ccb_r;
  logic [1:0]  mode_r;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ccb_r <= 16'h0; mode_r <= 2'b00;
    end else begin
      ccb_r  <= {12'h000, msix_fmask_r, msix_en_r && msix_impl, msi_en_r, intdis_r};
      mode_r <= mode;
    end
  end

  assign msi_ack_out        = ack_r;
  assign tx_valid           = tx_valid_r;
  assign tx_tlp             = tlp_r;
  assign irq_mode           = mode_r;
  assign config_control_bus = ccb_r;
  assign rx_app_valid       = rx_v_r;
  assign rx_app_data        = rx_d_r;
  assign root_int_status    = root_int_r;
  assign aer_root_status    = aer_root_status_r;
  assign crs_rdata          = rdata_r;
  assign crs_rvalid         = rvalid_r;

  // checks
  AST_ACK_AFTER_REQ: assert property (@(posedge clk_sys) disable iff (rst)
    msi_ack_out |-> $past(msi_req_in) && $past(msi_mode)) else $error("ack without request");
  AST_ONE_TLP: assert property (@(posedge clk_sys) disable iff (rst)
    msi_ack_out |-> tx_valid && tx_tlp.fmt_type == pig_pkg::TLP_MWR32) else $error("ack without write");
  AST_APP_TC: assert property (@(posedge clk_sys) disable iff (rst)
    msi_ack_out |-> tx_tlp.tc == $past(msi_traffic_class_in)) else $error("app tc lost");
  AST_INT_TC0: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(tx_valid) && !msi_ack_out |-> tx_tlp.tc == pig_pkg::traffic_class_zero) else $error("internal tc");
  AST_NO_MSI_IN_LEGACY: assert property (@(posedge clk_sys) disable iff (rst)
    !msi_en_r |=> !msi_ack_out) else $error("msi in wire mode");
  AST_ONE_MODE: assert property (@(posedge clk_sys) disable iff (rst)
    $onehot0({msi_mode, leg_mode, mode == pig_pkg::PIG_MODE_MSIX})) else $error("two modes");
  AST_ENABLE_GATE: assert property (@(posedge clk_sys) disable iff (rst)
    sel_brg |-> |(stat_r & enable_r)) else $error("disabled bit sent");
  AST_MBOX_SET: assert property (@(posedge clk_sys) disable iff (rst)
    crs_wr_mbox |=> stat_r[pig_pkg::MBOX_BIT_LO + $past(crs_addr[3:0])]) else $error("mailbox not set");
  AST_TLP_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_tlp)) else $error("tlp dropped");
  COV_APP_MSI: cover property (@(posedge clk_sys) disable iff (rst) msi_ack_out);
  COV_LEGACY: cover property (@(posedge clk_sys) disable iff (rst) leg_go);
  COV_BRIDGE: cover property (@(posedge clk_sys) disable iff (rst) go && sel_brg);
endmodule

// ---- include/pig_pkg.sv ----
// package: constants, types and field layouts of the interrupt generation block
package pig_pkg;
  // configuration space locations kept by the device
  localparam logic [11:0] CFG_CMD_OFS      = 12'h004;
  localparam int          CFG_CMD_INTDIS   = 10;
  localparam logic [11:0] CFG_MSI_OFS      = 12'h050;
  localparam int          CFG_MSI_EN_BIT   = 16;
  localparam int          CFG_MSI_MME_LO   = 20;
  localparam int          CFG_MSIX_EN_BIT  = 31;
  localparam int          CFG_MSIX_FM_BIT  = 30;
  localparam logic [11:0] CFG_MSI_ADDR_OFS = 12'h054;
  localparam logic [11:0] CFG_MSI_DATA_OFS = 12'h05C;
  localparam logic [11:0] CFG_AER_RES_OFS  = 12'h830;
  // bridge register offsets on the control register slave
  localparam logic [13:0] REG_STATUS_OFS   = 14'h0040;
  localparam logic [13:0] REG_ENABLE_OFS   = 14'h3070;
  localparam logic [13:0] REG_MAILBOX_OFS  = 14'h0800;
  localparam int          MBOX_BIT_LO      = 16;
  localparam int          NUM_MBOX         = 16;
  localparam int          NUM_IRQ_IN       = 16;
  localparam logic [31:0] ENABLE_RESET     = 32'h0000_0000;
  // msi vector classes with all 32 or with four allocated
  localparam logic [4:0]  VEC_SYSERR_32    = 5'h1F;
  localparam logic [4:0]  VEC_PME_32       = 5'h1E;
  localparam logic [4:0]  VEC_SYSERR_4     = 5'h03;
  localparam logic [4:0]  VEC_PME_4        = 5'h02;
  localparam logic [2:0]  MME_32           = 3'h5;
  localparam logic [2:0]  traffic_class_zero = 3'h0;
  // tlp header fields
  localparam logic [6:0]  TLP_MWR32        = 7'h40;
  localparam logic [6:0]  TLP_MSG_ASSERT   = 7'h34;
  localparam logic [7:0]  MSG_ASSERT_A     = 8'h20;
  localparam logic [7:0]  MSG_DEASSERT_A   = 8'h24;
  localparam logic [3:0]  LAST_BE_NONE     = 4'h0;
  localparam logic [3:0]  FIRST_BE_ALL     = 4'hF;

  typedef enum logic [1:0] {
    PIG_MODE_LEGACY = 2'b00,
    PIG_MODE_MSI    = 2'b01,
    PIG_MODE_MSIX   = 2'b10,
    PIG_MODE_NONE   = 2'b11
  } pig_mode_e;

  // one outgoing interrupt tlp
  typedef struct packed {
    logic [6:0]  fmt_type;
    logic [2:0]  tc;
    logic [3:0]  last_be;
    logic [3:0]  first_be;
    logic [7:0]  msg_code;
    logic [31:0] addr;
    logic [31:0] data;
  } pig_tlp_s;

  // configuration write from the link side
  typedef struct packed {
    logic        wr;
    logic [11:0] addr;
    logic [31:0] data;
  } pig_cfgwr_s;
endpackage

// ---- verilog/pig_msi_vec.sv ----
// module: maps an interrupt class onto the allocated msi vector
`timescale 1ns/1ps
module pig_msi_vec (
  input  wire logic [2:0] alloc_mme,
  input  wire logic [4:0] app_num,
  input  wire logic [1:0] src_class,
  input  wire logic [15:0] base_data,
  output logic [15:0]      msg_data
);
  logic [4:0] vec_mask;
  logic [4:0] vec_sel;
  logic       full32;

  // allocated count is 2**mme; app bits above it are dropped
  assign vec_mask = 5'((6'd1 << alloc_mme) - 6'd1);
  assign full32   = (alloc_mme == pig_pkg::MME_32);

  // class 0 app, 1 power/hot plug, 2 system error
  always_comb begin
    unique case (src_class)
      2'd1:    vec_sel = full32 ? pig_pkg::VEC_PME_32 : pig_pkg::VEC_PME_4;
      2'd2:    vec_sel = full32 ? pig_pkg::VEC_SYSERR_32 : pig_pkg::VEC_SYSERR_4;
      default: vec_sel = app_num & vec_mask;
    endcase
  end

  // low data bits carry the vector
  assign msg_data = {base_data[15:5], (base_data[4:0] & ~vec_mask) | (vec_sel & vec_mask)};
endmodule

// ---- tb/pig_app_model.sv ----
// partner model: application msi requester and link-side tlp sink
`timescale 1ns/1ps
module pig_app_model (
  input  wire logic       clk_sys,
  input  wire logic       msi_ack_out,
  input  wire logic       tx_valid,
  output logic            msi_req_in,
  output logic [2:0]      msi_traffic_class_in,
  output logic [4:0]      msi_num_in,
  output logic            tx_ready
);
  int stall = 0;
  int wait_cnt = 0;

  initial begin
    msi_req_in = 1'b0;
    msi_traffic_class_in = 3'h0;
    msi_num_in = 5'h00;
    tx_ready = 1'b0;
  end

  // sink keeps ready low for stall cycles of each tlp so the engine must wait
  always @(negedge clk_sys) begin
    if (!tx_valid || tx_ready) begin
      wait_cnt <= 0;
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= (wait_cnt >= stall);
      wait_cnt <= wait_cnt + 1;
    end
  end

  // request and its fields held until ack or lim cycles, then released to inverted values
  task automatic send_msi(input logic [2:0] tc, input logic [4:0] num, input int lim, output bit got);
    got = 1'b0;
    @(negedge clk_sys);
    msi_req_in = 1'b1;
    msi_traffic_class_in = tc;
    msi_num_in = num;
    for (int i = 0; i < lim && !got; i++) begin
      @(negedge clk_sys);
      got = (msi_ack_out === 1'b1);
    end
    msi_req_in = 1'b0;
    msi_traffic_class_in = ~tc;
    msi_num_in = ~num;
  endtask
endmodule

// ---- tb/tb.sv ----
// testbench: endpoint, bridge and root port interrupt scenarios
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic root_mode = 1'b0;
  logic msix_impl = 1'b1;
  pig_pkg::pig_cfgwr_s cfg_wr = '0;
  logic leg_in = 1'b0, pme_in = 1'b0, se_in = 1'b0, aer_in = 1'b0, msg_v = 1'b0, mwr_v = 1'b0;
  logic [7:0]  msg_c = 8'h00;
  logic [63:0] mwr_d = 64'h0;
  logic [15:0] birq = 16'h0000;
  logic        crs_wr = 1'b0, crs_rd = 1'b0;
  logic [13:0] crs_addr = 14'h0000;
  logic [31:0] crs_wdata = 32'h0;
  logic [4:0]  aer_num = 5'h01, pme_ofs = 5'h02;
  logic msi_req_in, msi_ack_out, tx_ready, tx_valid, rx_app_valid, crs_rvalid;
  logic [2:0]  msi_tc;
  logic [4:0]  msi_num;
  pig_pkg::pig_tlp_s tx_tlp, t;
  logic [1:0]  irq_mode;
  logic [15:0] ccb;
  logic [63:0] rx_app_data;
  logic [3:0]  root_int_status, exp_st;
  logic [31:0] aer_root_status, crs_rdata;
  int n_errors = 0;
  int tests_run = 0;
  bit got;

  always #2.5 clk_sys = ~clk_sys;

  pig_app_model app (.clk_sys(clk_sys), .msi_ack_out(msi_ack_out), .tx_valid(tx_valid), .msi_req_in(msi_req_in),
    .msi_traffic_class_in(msi_tc), .msi_num_in(msi_num), .tx_ready(tx_ready));

  pig_top dut (.clk_sys(clk_sys), .rst(rst), .root_mode(root_mode), .msix_impl(msix_impl), .cfg_wr(cfg_wr),
    .msi_req_in(msi_req_in), .msi_traffic_class_in(msi_tc), .msi_num_in(msi_num), .legacy_irq_vector_in(leg_in),
    .pme_event_in(pme_in), .syserr_event_in(se_in), .aer_msi_num_in(aer_num), .pme_msi_ofs_in(pme_ofs),
    .aer_err_log_in(aer_in), .rx_msg_valid(msg_v), .rx_msg_code(msg_c), .rx_mwr_valid(mwr_v), .rx_mwr_data(mwr_d),
    .bridge_irq_inputs(birq), .crs_wr(crs_wr), .crs_rd(crs_rd), .crs_addr(crs_addr), .crs_wdata(crs_wdata),
    .tx_ready(tx_ready), .msi_ack_out(msi_ack_out), .tx_valid(tx_valid), .tx_tlp(tx_tlp), .irq_mode(irq_mode),
    .config_control_bus(ccb), .rx_app_valid(rx_app_valid), .rx_app_data(rx_app_data),
    .root_int_status(root_int_status), .aer_root_status(aer_root_status), .crs_rdata(crs_rdata),
    .crs_rvalid(crs_rvalid));

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // reset for two cycles with the chosen port mode
  task automatic do_reset(input logic rm);
    @(negedge clk_sys);
    rst = 1'b1;
    root_mode = rm;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
  endtask

  // one-cycle config write pulse
  task automatic cfg(input logic [11:0] a, input logic [31:0] v);
    @(negedge clk_sys);
    cfg_wr = '{wr: 1'b1, addr: a, data: v};
    @(negedge clk_sys);
    cfg_wr = '0;
  endtask

  // register slave access; read answer lands one cycle after the request
  task automatic crs(input bit wr, input logic [13:0] a, input logic [31:0] v);
    @(negedge clk_sys);
    crs_wr = wr;
    crs_rd = !wr;
    crs_addr = a;
    crs_wdata = v;
    @(negedge clk_sys);
    crs_wr = 1'b0;
    crs_rd = 1'b0;
  endtask

  task automatic chk_rd(input logic [13:0] a, input logic [31:0] e);
    crs(1'b0, a, 32'h0);
    `CHK({crs_rvalid, crs_rdata}, {1'b1, e})
  endtask

  // bounded waits on the transmit side
  task automatic drain;
    for (int i = 0; i < 40 && tx_valid !== 1'b0; i++) @(negedge clk_sys);
    if (tx_valid !== 1'b0) begin
      n_errors++;
      end_sim();
    end
  endtask

  task automatic wait_tx;
    for (int i = 0; i < 40 && tx_valid !== 1'b1; i++) @(negedge clk_sys);
    if (tx_valid !== 1'b1) begin
      n_errors++;
      end_sim();
    end else t = tx_tlp;
  endtask

  task automatic chk_msg(input logic [7:0] code);
    wait_tx();
    `CHK({t.fmt_type, t.msg_code, t.tc}, {pig_pkg::TLP_MSG_ASSERT, code, pig_pkg::traffic_class_zero})
  endtask

  // internal event pulse, expected on traffic class zero with its class vector
  task automatic ev(input bit se, input logic [4:0] v);
    drain();
    @(negedge clk_sys);
    se_in = se;
    pme_in = !se;
    @(negedge clk_sys);
    se_in = 1'b0;
    pme_in = 1'b0;
    wait_tx();
    `CHK({t.tc, t.data[4:0]}, {pig_pkg::traffic_class_zero, v})
  endtask

  task automatic rx_msg(input logic [7:0] code);
    @(negedge clk_sys);
    msg_v = 1'b1;
    msg_c = code;
    @(negedge clk_sys);
    msg_v = 1'b0;
    exp_st[code[1:0]] = !code[2];
    `CHK(root_int_status, exp_st)
  endtask

  initial begin
    do_reset(1'b0);
    `CHK(irq_mode, pig_pkg::PIG_MODE_LEGACY)
    app.send_msi(3'h2, 5'h01, 8, got);
    `CHK(got, 1'b0)
    // wire mode: application level drives assert and deassert messages
    leg_in = 1'b1;
    chk_msg(pig_pkg::MSG_ASSERT_A);
    drain();
    leg_in = 1'b0;
    chk_msg(pig_pkg::MSG_DEASSERT_A);
    // bridge: status following input level, mailbox w1c, enable gating
    chk_rd(pig_pkg::REG_ENABLE_OFS, pig_pkg::ENABLE_RESET);
    chk_rd(14'h0100, 32'h0000_0000);
    birq = 16'h0020;
    repeat (6) @(negedge clk_sys);
    `CHK(tx_valid, 1'b0)
    chk_rd(pig_pkg::REG_STATUS_OFS, 32'h0000_0020);
    crs(1'b1, pig_pkg::REG_MAILBOX_OFS + 14'h0003, 32'h0000_0001);
    chk_rd(pig_pkg::REG_STATUS_OFS, 32'h0008_0020);
    crs(1'b1, pig_pkg::REG_ENABLE_OFS, 32'h0000_0020);
    chk_msg(pig_pkg::MSG_ASSERT_A);
    chk_rd(pig_pkg::REG_ENABLE_OFS, 32'h0000_0020);
    crs(1'b1, pig_pkg::REG_STATUS_OFS, 32'h0008_0000);
    chk_rd(pig_pkg::REG_STATUS_OFS, 32'h0000_0020);
    drain();
    birq = 16'h0000;
    chk_msg(pig_pkg::MSG_DEASSERT_A);
    // switch to msi with four vectors: enable new type before disabling old
    cfg(pig_pkg::CFG_MSI_ADDR_OFS, 32'hFEE0_1000);
    cfg(pig_pkg::CFG_MSI_DATA_OFS, 32'h0000_AB00);
    cfg(pig_pkg::CFG_MSI_OFS, 32'h0021_0000);
    cfg(pig_pkg::CFG_CMD_OFS, 32'h0000_0400);
    @(negedge clk_sys);
    `CHK({irq_mode, ccb[1:0]}, {pig_pkg::PIG_MODE_MSI, 2'b11})
    app.stall = 3;
    app.send_msi(3'h5, 5'h03, 8, got);
    `CHK({got, tx_valid}, 2'b11)
    t = tx_tlp;
    `CHK({t.fmt_type, t.tc, t.last_be, t.addr, t.data[15:0]}, {pig_pkg::TLP_MWR32, 3'h5, pig_pkg::LAST_BE_NONE, 32'hFEE0_1000, 16'hAB03})
    app.send_msi(3'h1, 5'h01, 20, got);
    `CHK({got, tx_tlp.tc, tx_tlp.data[15:0]}, {1'b1, 3'h1, 16'hAB01})
    ev(1'b0, pig_pkg::VEC_PME_4);
    ev(1'b1, pig_pkg::VEC_SYSERR_4);
    cfg(pig_pkg::CFG_MSI_OFS, {8'h00, 1'b0, pig_pkg::MME_32, 4'h1, 16'h0000});
    ev(1'b0, pig_pkg::VEC_PME_32);
    ev(1'b1, pig_pkg::VEC_SYSERR_32);
    drain();
    app.send_msi(3'h3, 5'h1D, 8, got);
    `CHK({got, tx_tlp.data[4:0]}, {1'b1, 5'h1D})
    // msi-x enabled and masked: bits exposed, msi refused
    drain();
    cfg(pig_pkg::CFG_MSI_OFS, 32'hC000_0000);
    @(negedge clk_sys);
    `CHK({irq_mode, ccb[3:0]}, {pig_pkg::PIG_MODE_MSIX, 4'b1101})
    app.send_msi(3'h0, 5'h01, 8, got);
    `CHK(got, 1'b0)
    // root port: received writes, wire messages, error status
    do_reset(1'b1);
    @(negedge clk_sys);
    mwr_v = 1'b1;
    mwr_d = 64'h1234_5678_9ABC_DEF0;
    @(negedge clk_sys);
    mwr_v = 1'b0;
    `CHK({rx_app_valid, rx_app_data}, {1'b1, 64'h1234_5678_9ABC_DEF0})
    exp_st = 4'h0;
    for (int m = 0; m < 8; m++) rx_msg(8'h20 + 8'(m));
    @(negedge clk_sys);
    aer_in = 1'b1;
    @(negedge clk_sys);
    aer_in = 1'b0;
    @(negedge clk_sys);
    `CHK(aer_root_status[0], 1'b1)
    cfg(pig_pkg::CFG_AER_RES_OFS, 32'h0000_0001);
    @(negedge clk_sys);
    `CHK(aer_root_status[0], 1'b0)
    // root self-interrupts once msi is on: logged error waits, then power event
    cfg(pig_pkg::CFG_MSI_OFS, {8'h00, 1'b0, pig_pkg::MME_32, 4'h1, 16'h0000});
    wait_tx();
    `CHK({t.tc, t.data[4:0]}, {pig_pkg::traffic_class_zero, aer_num})
    ev(1'b0, pme_ofs);
    end_sim();
  end
endmodule
